// File: tdfc_pkg.sv
// constants, field layout and state codes for the two-dimensional line coder
package tdfc_pkg;
  // line geometry
  localparam int LINE_W = 32;
  localparam int RUN_BITS = 6;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PARAM = 8'h04;
  localparam logic [7:0] OFS_LINE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_EXP_CTRL = 8'h10;
  localparam logic [7:0] OFS_EXP_LINE = 8'h14;
  // compressor_mode_ctrl / expander_mode_ctrl fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_START_BIT = 4;
  localparam int EXP_DUP_LSB = 8;
  // compressor_param_reg fields
  localparam int PARAM_SA_BIT = 0;
  localparam int PARAM_EOLF_BIT = 1;
  localparam int PARAM_DFC_LSB = 2;
  localparam int PARAM_K_LSB = 4;
  localparam int PARAM_SKIP_LSB = 8;
  localparam int PARAM_LAST_BIT = 12;
  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  localparam int STAT_PFX_OK_BIT = 2;
  localparam int STAT_PFX_ERR_BIT = 3;
  localparam int STAT_LINES_LSB = 16;
  // reset values
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [1:0] RST_DFC = 2'h0;
  localparam logic [3:0] RST_K = 4'h0;
  localparam logic [3:0] RST_SKIP = 4'h0;
  localparam logic [3:0] RST_DUP = 4'h0;
  // coding_mode_field and data_format_field encodings
  localparam logic [1:0] MODE_ONE_D = 2'b01;
  localparam logic [1:0] MODE_TWO_D = 2'b10;
  localparam logic [1:0] DFC_RTC = 2'b01;
  localparam logic [1:0] DFC_EOP = 2'b11;
  // code words and lengths
  localparam logic [11:0] EOL_CODE = 12'h001;
  localparam logic [4:0] EOL_LEN = 5'd12;
  localparam logic [3:0] PASS_CODE = 4'h1;
  localparam logic [4:0] PASS_LEN = 5'd4;
  localparam logic [2:0] HORZ_CODE = 3'h1;
  localparam logic [4:0] HORZ_LEN = 5'd9;
  localparam logic [4:0] RUN_LEN = 5'd6;
  localparam logic [2:0] RTC_COUNT = 3'd6;
  localparam logic [2:0] EOP_COUNT = 3'd2;
  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_PREFIX = 4'b0001, S_WAIT = 4'b0010, S_CODE = 4'b0011,
    S_HRUN2 = 4'b0100, S_RUN1D = 4'b0101, S_EOL = 4'b0110, S_ALIGN = 4'b0111,
    S_TRAIL = 4'b1000
  } tdfc_state_type;
endpackage : tdfc_pkg

// File: tdfc_line_coder.sv
// two-dimensional fax line coder with line duplication and prefix check
// How it works
// - coded line becomes next reference line
// - first line 1-D, then K-1 2-D lines
// - emit EOL prefix, expander checks for it
// - mode field 10 selects two-dimensional coding
// - start marker select inserts starting EOL
// - interval field sets lines per group
// - interval zero codes every line 2-D
// - format 00 aligns lines, 01 appends RTC
// - format 10 unaligned, 11 appends end-of-page
// - terminator field 1 suppresses line EOLs
// - Group 4 white reference, no line EOLs
// - start position is imaginary white pixel
// - coding changes follow start, opposite colour
// - reference changes follow start, opposite colour
// - pass code when a1 beyond b2
// - after pass, reference changes re-searched
// - vertical code for offsets within three
// - after vertical, start moves to a1
// - horizontal prefix 001 plus two runs
// - after horizontal, start moves to a2
// - skip configured lines after each coded line
// - skipped coding references last coded line
// - expander repeats each line configured times
// - terminator field 0 appends EOL per line, except in Group 4
// - return-to-control is six EOLs
// - vertical code words per offset table
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
module tdfc_line_coder (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // compressed bit stream out
  output logic code_bit_o,
  output logic code_valid_o,
  input wire logic code_ready_i,
  // expander bit stream in, prefix check only
  input wire logic exp_bit_i,
  input wire logic exp_bit_valid_i,
  // duplicated expanded lines out
  output logic [tdfc_pkg::LINE_W-1:0] exp_line_o,
  output logic exp_line_valid_o,
  input wire logic exp_line_ready_i
);
  import tdfc_pkg::*;

  typedef struct packed {
    tdfc_state_type st;
    logic [1:0] mode;
    logic [1:0] emode;
    logic sa;
    logic eolf;
    logic last;
    logic [1:0] dfc;
    logic [3:0] kint;
    logic [3:0] skip;
    logic [3:0] dup;
    logic [LINE_W-1:0] cur;
    logic [LINE_W-1:0] ref_line;
    logic [5:0] a0;
    logic a0_start;
    logic a0_col;
    logic [15:0] sh;
    logic [4:0] len;
    logic [2:0] bitpos;
    logic [3:0] icnt;
    logic [3:0] skip_left;
    logic [2:0] eol_left;
    logic fin;
    logic [5:0] run2;
    logic [15:0] lines;
    logic rd_pend;
    logic [31:0] rdata;
    logic [3:0] pfx_cnt;
    logic pfx_ok;
    logic pfx_err;
    logic [LINE_W-1:0] exp_line;
    logic [3:0] dup_left;
    logic xv;
  } tdfc_regs_type;

  tdfc_regs_type s;
  tdfc_regs_type next_s;

  // next change right of from; none found gives the past-the-end position
  function automatic logic [6:0] tdfc_next_chg(input logic [LINE_W-1:0] ln, input int from,
                                              input logic chk, input logic col);
    int r;
    logic prev;
    r = LINE_W;
    for (int i = LINE_W - 1; i >= 0; i--) begin
      prev = (i == 0) ? 1'b0 : ln[(i == 0) ? 0 : i - 1];
      if (i > from && ln[i] != prev && (!chk || ln[i] == col)) begin
        r = i;
      end
    end
    return 7'(r);
  endfunction : tdfc_next_chg

  // vertical code word {length, bits} for offset a1 - b1
  function automatic logic [11:0] tdfc_vcode(input int d);
    case (d)
      1: return {4'd3, 8'h03};
      2: return {4'd6, 8'h03};
      3: return {4'd7, 8'h03};
      -1: return {4'd3, 8'h02};
      -2: return {4'd6, 8'h02};
      -3: return {4'd7, 8'h02};
      default: return {4'd1, 8'h01};
    endcase
  endfunction : tdfc_vcode

  // left-align a code word in the output shifter
  function automatic logic [15:0] tdfc_place(input logic [15:0] v, input logic [4:0] l);
    return v << (5'd16 - l);
  endfunction : tdfc_place

  // register read view, also the base for byte-lane merges
  function automatic logic [31:0] tdfc_rmux(input tdfc_regs_type r, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      OFS_CTRL: v[CTRL_MODE_LSB +: 2] = r.mode;
      OFS_PARAM: begin
        v[PARAM_SA_BIT] = r.sa;
        v[PARAM_EOLF_BIT] = r.eolf;
        v[PARAM_DFC_LSB +: 2] = r.dfc;
        v[PARAM_K_LSB +: 4] = r.kint;
        v[PARAM_SKIP_LSB +: 4] = r.skip;
        v[PARAM_LAST_BIT] = r.last;
      end
      OFS_STATUS: begin
        v[STAT_BUSY_BIT] = (r.st != S_IDLE);
        v[STAT_READY_BIT] = (r.st == S_WAIT);
        v[STAT_PFX_OK_BIT] = r.pfx_ok;
        v[STAT_PFX_ERR_BIT] = r.pfx_err;
        v[STAT_LINES_LSB +: 16] = r.lines;
      end
      OFS_EXP_CTRL: begin
        v[CTRL_MODE_LSB +: 2] = r.emode;
        v[EXP_DUP_LSB +: 4] = r.dup;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : tdfc_rmux

  // change points for the current start position
  int a0i;
  logic [6:0] a1;
  logic [6:0] a2;
  logic [6:0] b1;
  logic [6:0] b2;
  int diff;
  logic free;
  logic pass_c;
  logic vert_c;
  logic g4;
  logic [5:0] base;
  assign a0i = s.a0_start ? -1 : int'(s.a0);
  assign a1 = tdfc_next_chg(s.cur, a0i, 1'b0, 1'b0);
  assign a2 = tdfc_next_chg(s.cur, int'(a1), 1'b0, 1'b0);
  assign b1 = tdfc_next_chg(s.ref_line, a0i, 1'b1, ~s.a0_col);
  assign b2 = tdfc_next_chg(s.ref_line, int'(b1), 1'b0, 1'b0);
  assign diff = int'(a1) - int'(b1);
  assign pass_c = (b2 < a1);
  assign vert_c = (diff >= -3) && (diff <= 3);
  assign g4 = (s.mode == MODE_TWO_D) && (s.kint == 4'h0);
  assign free = (s.len == 5'd0);
  assign base = s.a0_start ? 6'd0 : s.a0;

  // bus handshake: line writes stall until the coder is ready for one
  logic wr_acc;
  logic [31:0] wmerged;
  logic line_acc;
  logic [31:0] rview;
  assign avs_waitrequest_o = !ce_i || (avs_read_i && !s.rd_pend)
    || (avs_write_i && avs_address_i == OFS_LINE && s.st != S_WAIT)
    || (avs_write_i && avs_address_i == OFS_EXP_LINE && s.xv);
  assign wr_acc = avs_write_i && !avs_waitrequest_o;
  assign line_acc = wr_acc && avs_address_i == OFS_LINE && s.skip_left == 4'h0;
  // read view held in a net, a function result cannot be part-selected
  assign rview = tdfc_rmux(s, avs_address_i);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmerged[8*i +: 8] = avs_byteenable_i[i] ? avs_writedata_i[8*i +: 8] : rview[8*i +: 8];
    end
  end

  // next state of the whole block
  always_comb begin
    logic [11:0] vc;
    next_s = s;
    vc = tdfc_vcode(diff);
    // output shifter drains one bit per accepted cycle
    if (!free && code_ready_i) begin
      next_s.sh = {s.sh[14:0], 1'b0};
      next_s.len = s.len - 5'd1;
      next_s.bitpos = s.bitpos + 3'd1;
    end
    // one wait cycle gives registered read data
    if (avs_read_i && !s.rd_pend) begin
      next_s.rd_pend = 1'b1;
      next_s.rdata = tdfc_rmux(s, avs_address_i);
    end else if (avs_read_i) begin
      next_s.rd_pend = 1'b0;
    end
    // register writes
    if (wr_acc && avs_address_i == OFS_PARAM) begin
      next_s.sa = wmerged[PARAM_SA_BIT];
      next_s.eolf = wmerged[PARAM_EOLF_BIT];
      next_s.dfc = wmerged[PARAM_DFC_LSB +: 2];
      next_s.kint = wmerged[PARAM_K_LSB +: 4];
      next_s.skip = wmerged[PARAM_SKIP_LSB +: 4];
      next_s.last = wmerged[PARAM_LAST_BIT];
    end
    if (wr_acc && avs_address_i == OFS_EXP_CTRL) begin
      next_s.emode = wmerged[CTRL_MODE_LSB +: 2];
      next_s.dup = wmerged[EXP_DUP_LSB +: 4];
      if (wmerged[CTRL_START_BIT]) begin
        next_s.pfx_cnt = 4'h0;
        next_s.pfx_ok = 1'b0;
        next_s.pfx_err = 1'b0;
      end
    end
    // expander expects the leading EOL before any line data
    if (exp_bit_valid_i && !s.pfx_ok && !s.pfx_err) begin
      if (exp_bit_i != EOL_CODE[4'd11 - s.pfx_cnt]) begin
        next_s.pfx_err = 1'b1;
      end else if (s.pfx_cnt == 4'd11) begin
        next_s.pfx_ok = 1'b1;
      end else begin
        next_s.pfx_cnt = s.pfx_cnt + 4'h1;
      end
    end
    // duplicated line output, extra copies counted down
    if (wr_acc && avs_address_i == OFS_EXP_LINE) begin
      next_s.exp_line = avs_writedata_i[LINE_W-1:0];
      next_s.xv = 1'b1;
      next_s.dup_left = s.dup;
    end else if (s.xv && exp_line_ready_i) begin
      if (s.dup_left != 4'h0) begin
        next_s.dup_left = s.dup_left - 4'h1;
      end else begin
        next_s.xv = 1'b0;
      end
    end
    // document start; a new document always sees an all-white reference
    if (wr_acc && avs_address_i == OFS_CTRL) begin
      next_s.mode = wmerged[CTRL_MODE_LSB +: 2];
      if (wmerged[CTRL_START_BIT] && s.st == S_IDLE
          && (wmerged[1:0] == MODE_ONE_D || wmerged[1:0] == MODE_TWO_D)) begin
        next_s.ref_line = '0;
        next_s.icnt = 4'h0;
        next_s.skip_left = 4'h0;
        next_s.lines = 16'h0000;
        next_s.fin = 1'b0;
        next_s.st = s.sa ? S_PREFIX : S_WAIT;
      end
    end
    // line write: discarded while skipping, else starts coding
    if (wr_acc && avs_address_i == OFS_LINE) begin
      if (s.skip_left != 4'h0) begin
        next_s.skip_left = s.skip_left - 4'h1;
      end else begin
        next_s.cur = avs_writedata_i[LINE_W-1:0];
        next_s.a0 = 6'd0;
        next_s.a0_start = 1'b1;
        next_s.a0_col = 1'b0;
        next_s.icnt = (s.icnt + 4'h1 >= s.kint) ? 4'h0 : s.icnt + 4'h1;
        if (s.mode == MODE_ONE_D || (s.kint != 4'h0 && s.icnt == 4'h0)) begin
          next_s.st = S_RUN1D;
        end else begin
          next_s.st = S_CODE;
        end
      end
    end
    // coding sequencer, loads the shifter only once it is empty
    case (s.st)
      S_IDLE: begin
      end
      S_PREFIX: begin
        if (free) begin
          next_s.sh = tdfc_place(16'(EOL_CODE), EOL_LEN);
          next_s.len = EOL_LEN;
          next_s.st = S_WAIT;
        end
      end
      S_WAIT: begin
      end
      S_CODE: begin
        if (free) begin
          next_s.a0_start = 1'b0;
          if (pass_c) begin
            next_s.sh = tdfc_place(16'(PASS_CODE), PASS_LEN);
            next_s.len = PASS_LEN;
            next_s.a0 = b2[5:0];
          end else if (vert_c) begin
            next_s.sh = tdfc_place(16'(vc[7:0]), 5'(vc[11:8]));
            next_s.len = 5'(vc[11:8]);
            next_s.a0 = a1[5:0];
            next_s.a0_col = ~s.a0_col;
            if (a1 >= 7'(LINE_W)) begin
              next_s.st = S_EOL;
            end
          end else begin
            next_s.sh = tdfc_place(16'({HORZ_CODE, 6'(a1[5:0] - base)}), HORZ_LEN);
            next_s.len = HORZ_LEN;
            next_s.run2 = 6'(a2[5:0] - a1[5:0]);
            next_s.a0 = a2[5:0];
            next_s.st = S_HRUN2;
          end
        end
      end
      S_HRUN2: begin
        if (free) begin
          next_s.sh = tdfc_place(16'(s.run2), RUN_LEN);
          next_s.len = RUN_LEN;
          next_s.st = (s.a0 >= 6'(LINE_W)) ? S_EOL : S_CODE;
        end
      end
      S_RUN1D: begin
        if (free) begin
          next_s.sh = tdfc_place(16'(6'(a1[5:0] - base)), RUN_LEN);
          next_s.len = RUN_LEN;
          next_s.a0 = a1[5:0];
          next_s.a0_start = 1'b0;
          if (a1 >= 7'(LINE_W)) begin
            next_s.st = S_EOL;
          end
        end
      end
      S_EOL: begin
        if (free) begin
          next_s.ref_line = s.cur;
          next_s.lines = s.lines + 16'h0001;
          next_s.skip_left = s.skip;
          if (!s.eolf && !g4) begin
            next_s.sh = tdfc_place(16'(EOL_CODE), EOL_LEN);
            next_s.len = EOL_LEN;
          end
          next_s.st = S_ALIGN;
        end
      end
      S_ALIGN: begin
        if (free) begin
          if ((s.fin || !s.dfc[1]) && s.bitpos != 3'd0) begin
            next_s.len = 5'd8 - 5'(s.bitpos);
            next_s.sh = 16'h0000;
          end else if (s.fin) begin
            next_s.st = S_IDLE;
          end else if (s.last) begin
            next_s.fin = 1'b1;
            next_s.eol_left = (s.dfc == DFC_RTC) ? RTC_COUNT
                            : (s.dfc == DFC_EOP) ? EOP_COUNT : 3'd0;
            next_s.st = S_TRAIL;
          end else begin
            next_s.st = S_WAIT;
          end
        end
      end
      S_TRAIL: begin
        if (free) begin
          if (s.eol_left != 3'd0) begin
            next_s.sh = tdfc_place(16'(EOL_CODE), EOL_LEN);
            next_s.len = EOL_LEN;
            next_s.eol_left = s.eol_left - 3'd1;
          end else begin
            next_s.st = S_ALIGN;
          end
        end
      end
      default: next_s.st = S_IDLE;
    endcase
  end

  // all state registered together; ce low freezes everything
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s <= '0;
      s.st <= S_IDLE;
      s.mode <= RST_MODE;
      s.dfc <= RST_DFC;
      s.kint <= RST_K;
      s.skip <= RST_SKIP;
      s.dup <= RST_DUP;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  // outputs
  assign avs_readdata_o = s.rdata;
  assign code_bit_o = s.sh[15];
  assign code_valid_o = !free;
  assign exp_line_o = s.exp_line;
  assign exp_line_valid_o = s.xv;

  // checks; they assume ce_i stays high
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  logic step;
  assign step = ce_i && free;
  sequence seq_eol_loaded;
    s.len == EOL_LEN && s.sh[15:4] == EOL_CODE;
  endsequence
  a_ref_update: assert property (s.st == S_EOL && step |=> s.ref_line == $past(s.cur))
    else $error("reference line not taken from coded line");
  a_pass_code: assert property (s.st == S_CODE && step && pass_c
    |=> s.len == PASS_LEN && s.sh[15:12] == PASS_CODE && s.a0 == $past(b2[5:0]))
    else $error("pass mode code or move wrong");
  a_vert_move: assert property (s.st == S_CODE && step && !pass_c && vert_c
    |=> s.a0 == $past(a1[5:0]) && s.a0_col != $past(s.a0_col))
    else $error("vertical mode did not move start to a1");
  a_vert_zero: assert property (s.st == S_CODE && step && !pass_c && diff == 0
    |=> s.len == 5'd1 && s.sh[15])
    else $error("zero offset vertical code wrong");
  // prefix and first run go out together, the second run follows once drained
  sequence seq_horz_loaded;
    s.st == S_HRUN2 && s.len == HORZ_LEN && s.sh[15:13] == HORZ_CODE;
  endsequence
  sequence seq_run2_loaded;
    $past(s.st) == S_HRUN2 && s.st != S_HRUN2 && s.len == RUN_LEN && s.sh[15:10] == s.run2;
  endsequence
  a_horz_runs: assert property (s.st == S_CODE && step && !pass_c && !vert_c
    |=> seq_horz_loaded ##[1:300] seq_run2_loaded)
    else $error("horizontal mode sequence wrong");
  a_one_d_pick: assert property (line_acc && s.mode == MODE_TWO_D && s.kint != 4'h0
    && s.icnt == 4'h0 |=> s.st == S_RUN1D)
    else $error("group line not coded one-dimensionally");
  a_inf_int: assert property (line_acc && s.mode == MODE_TWO_D && s.kint == 4'h0
    |=> s.st == S_CODE)
    else $error("zero interval produced a one-dimensional line");
  a_eol_auto: assert property (s.st == S_EOL && step && !s.eolf && !g4
    |=> seq_eol_loaded)
    else $error("automatic end-of-line missing");
  a_eol_omit: assert property (s.st == S_EOL && step && s.eolf |=> free)
    else $error("end-of-line sent although suppressed");
  a_prefix_eol: assert property (s.st == S_PREFIX && step |=> seq_eol_loaded)
    else $error("starting end-of-line missing");
  a_skip_drop: assert property (ce_i && wr_acc && avs_address_i == OFS_LINE
    && s.skip_left != 4'h0 |=> $stable(s.cur) && s.st == S_WAIT)
    else $error("skipped line was coded");
  a_dup_repeat: assert property (ce_i && s.xv && exp_line_ready_i && s.dup_left != 4'h0
    && !wr_acc |=> s.xv && $stable(s.exp_line))
    else $error("duplicated line dropped early");
  a_align_pad: assert property (s.st == S_ALIGN && step && !s.dfc[1] && s.bitpos != 3'd0
    |=> s.len == 5'd8 - 5'($past(s.bitpos)))
    else $error("byte alignment pad length wrong");
endmodule : tdfc_line_coder

// File: tdfc_code_sink.sv
// destination-side model that collects the coded bit stream
`timescale 1ns/1ns
module tdfc_code_sink (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // bench control
  input wire logic clear_i,
  input wire logic slow_i,
  // coded stream from the coder
  input wire logic code_bit_i,
  input wire logic code_valid_i,
  output logic code_ready_o,
  // collected bits, newest in bit 0
  output logic [127:0] bits_o,
  output logic [7:0] count_o
);
  // slow mode accepts every other cycle so the coder must hold its bit
  // only takes bits, never splices uncompressed data into the stream
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || clear_i) begin
      bits_o <= 128'h0;
      count_o <= 8'h00;
      code_ready_o <= 1'b0;
    end else begin
      code_ready_o <= slow_i ? ~code_ready_o : 1'b1;
      if (code_valid_i && code_ready_o) begin
        bits_o <= {bits_o[126:0], code_bit_i};
        count_o <= count_o + 8'h01;
      end
    end
  end
endmodule : tdfc_code_sink

// File: tb_tdfc_line_coder.sv
// self-checking bench for the two-dimensional line coder
`timescale 1ns/1ns
module tb_tdfc_line_coder;
  import tdfc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, code_bit_o, code_valid_o, code_ready_i;
  logic exp_bit_i = 1'b0;
  logic exp_bit_valid_i = 1'b0;
  logic exp_line_ready_i = 1'b0;
  logic [LINE_W-1:0] exp_line_o;
  logic exp_line_valid_o;
  logic clear = 1'b0;
  logic slow = 1'b0;
  logic [127:0] sink_bits;
  logic [7:0] sink_count;
  logic [31:0] lines [$];
  int mismatches = 0;
  int samples_checked = 0;

  tdfc_line_coder u_tdfc_line_coder (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(1'b1),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .code_bit_o(code_bit_o), .code_valid_o(code_valid_o), .code_ready_i(code_ready_i),
    .exp_bit_i(exp_bit_i), .exp_bit_valid_i(exp_bit_valid_i),
    .exp_line_o(exp_line_o), .exp_line_valid_o(exp_line_valid_o),
    .exp_line_ready_i(exp_line_ready_i)
  );
  tdfc_code_sink u_tdfc_code_sink (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .clear_i(clear), .slow_i(slow),
    .code_bit_i(code_bit_o), .code_valid_i(code_valid_o), .code_ready_o(code_ready_i),
    .bits_o(sink_bits), .count_o(sink_count)
  );

  // free-running 100 MHz clock
  always #5 ref_clk_i = ~ref_clk_i;

  task close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  task check(input string name, input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // request held until waitrequest is sampled low at a rising edge
  task av_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= 1'b1;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask : av_write

  task av_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o;
    avs_read_i <= 1'b0;
  endtask : av_read

  // polls status until the coder asks for its next line
  task wait_ready;
    logic [31:0] d;
    int i;
    d = 32'h0;
    for (i = 0; i < 200 && d[STAT_READY_BIT] !== 1'b1; i++) av_read(OFS_STATUS, d);
  endtask : wait_ready

  // codes the queued lines; the last one goes with p_last so the trailer is set late
  task run_doc(input string name, input logic [1:0] mode, input logic [31:0] p_first,
               input logic [31:0] p_last, input logic [127:0] exp, input int n);
    int i;
    @(posedge ref_clk_i);
    clear <= 1'b1;
    @(posedge ref_clk_i);
    clear <= 1'b0;
    av_write(OFS_PARAM, p_first);
    av_write(OFS_CTRL, {30'h0, mode} | 32'h0000_0010);
    foreach (lines[j]) begin
      if (j == lines.size() - 1) begin
        wait_ready();
        av_write(OFS_PARAM, p_last);
      end
      av_write(OFS_LINE, lines[j]);
    end
    for (i = 0; i < 3000 && sink_count < n; i++) @(posedge ref_clk_i);
    repeat (30) @(posedge ref_clk_i);
    check({name, " count"}, 128'(sink_count), 128'(n));
    check(name, sink_bits, exp);
  endtask : run_doc

  task test_regs;
    logic [31:0] d;
    av_read(OFS_STATUS, d);
    check("status reset", d, 32'h0);
    av_read(OFS_PARAM, d);
    check("param reset", d, {20'h0, RST_SKIP, RST_K, RST_DFC, 2'h0});
    av_read(8'h20, d);
    check("unmapped read", d, 32'h0);
  endtask : test_regs

  task test_g3_1d;
    lines = '{32'h0};
    run_doc("one-d page", MODE_ONE_D, 32'h0000_0005, 32'h0000_1005,
            {EOL_CODE, 6'h20, EOL_CODE, 2'h0, {6{EOL_CODE}}}, 104);
  endtask : test_g3_1d

  task test_interval;
    lines = '{32'h0, 32'h0};
    run_doc("interval two", MODE_TWO_D, 32'h0000_0028, 32'h0000_102C,
            {6'h20, EOL_CODE, 1'h1, {3{EOL_CODE}}, 1'h0}, 56);
  endtask : test_interval

  // white reference, then horizontal, right offsets and a pass
  task test_g4;
    slow <= 1'b1;
    lines = '{32'h0000_0F00, 32'h0000_1E00, 32'hF000_0000};
    run_doc("all two-d", MODE_TWO_D, 32'h0000_000A, 32'h0000_100E,
            {HORZ_CODE, 6'h08, 6'h04, 1'h1, 3'h3, 3'h3, 1'h1, PASS_CODE, HORZ_CODE,
             6'h0F, 6'h04, EOL_CODE, EOL_CODE, 6'h00}, 72);
    slow <= 1'b0;
  endtask : test_g4

  // middle line is skipped, so the last line refers to the first
  task test_skip;
    lines = '{32'h0000_0F00, 32'hFFFF_FFFF, 32'h0000_1E00};
    run_doc("skip one", MODE_TWO_D, 32'h0000_010A, 32'h0000_110E,
            {HORZ_CODE, 6'h08, 6'h04, 1'h1, 3'h3, 3'h3, 1'h1, EOL_CODE, EOL_CODE,
             1'h0}, 48);
  endtask : test_skip

  task test_dup;
    int seen;
    int i;
    logic [31:0] d;
    seen = 0;
    av_write(OFS_EXP_CTRL, 32'h0000_0202);
    av_read(OFS_EXP_CTRL, d);
    check("expander mode", d, 32'h0000_0202);
    av_write(OFS_EXP_LINE, 32'hA5C3_0F81);
    repeat (5) @(posedge ref_clk_i);
    exp_line_ready_i <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk_i);
      if (exp_line_valid_o === 1'b1) begin
        seen++;
        check("dup line", exp_line_o, 32'hA5C3_0F81);
      end
    end
    exp_line_ready_i <= 1'b0;
    check("dup copies", seen, 3);
  endtask : test_dup

  // released data line shows the inverse of its last bit
  task feed(input logic [11:0] w);
    int i;
    for (i = 11; i >= 0; i--) begin
      @(posedge ref_clk_i);
      exp_bit_i <= w[i];
      exp_bit_valid_i <= 1'b1;
    end
    @(posedge ref_clk_i);
    exp_bit_valid_i <= 1'b0;
    exp_bit_i <= ~w[0];
  endtask : feed

  task test_prefix;
    logic [31:0] d;
    av_write(OFS_EXP_CTRL, 32'h0000_0010);
    feed(EOL_CODE);
    av_read(OFS_STATUS, d);
    check("prefix good", d[3:2], 2'h1);
    av_write(OFS_EXP_CTRL, 32'h0000_0010);
    feed(12'h003);
    av_read(OFS_STATUS, d);
    check("prefix bad", d[3:2], 2'h2);
  endtask : test_prefix

  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    test_regs();
    test_g3_1d();
    test_interval();
    test_g4();
    test_skip();
    test_dup();
    test_prefix();
    close_out();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    mismatches++;
    close_out();
  end
endmodule : tb_tdfc_line_coder
